// [include/cifl_pkg.sv]
// Purpose: Shared constants and types of the core interrupt flag logic
// Assumes: One 40 MHz clock, four clocks per instruction cycle (Q1..Q4)
// Notes: Register offsets are word indices; byte address is four times the index
// Behaviour
// - External pin detects rising edge when polarity bit is 1, falling when 0.
// - A qualifying external edge sets the external pin flag, control bit 1.
// - External pin request is masked while its enable, control bit 4, is clear.
// - External pin wakes from sleep only if enabled before sleep began.
// - After interrupt wake-up, vector to 0004h only if global enable is set.
// - Timer count wrapping FFh to 00h sets the timer flag, control bit 2.
// - Timer request is gated by its enable, control bit 5.
// - Any change on monitored port pins sets the port change flag, bit 0.
// - Port change request is gated by its enable, control bit 3.
// - A pin takes part in change detection only when its mask bit is set.
// - A change coinciding with a port read at Q2 may be missed.
// - Event to vector takes three to four instruction cycles, any instruction length.
// - The external flag may be set during phases Q4 through Q1.
// - Taking an interrupt pushes only the return program counter.
// - The lowest 16 bytes of every bank map to shared locations.
// - Global enable, bit 7, passes unmasked requests when set; clears on reset.
// - Servicing clears global enable, pushes return address, loads 0004h.
// - Every flag is set by its event regardless of any enable.
// - Return from interrupt sets global enable again.
`default_nettype none
package cifl_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int Q_PHASES = 4;
  localparam int ADDR_W = 10;
  localparam int PC_W = 13;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL_STATUS = 8'h0b;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
  localparam logic [7:0] IDX_PERIPHERAL_FLAGS_TWO = 8'h0d;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLES_TWO = 8'h8d;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PCMASK = 8'h96;
  localparam int B_PCF = 0;
  localparam int B_EXTF = 1;
  localparam int B_TMRF = 2;
  localparam int B_PCE = 3;
  localparam int B_EXTE = 4;
  localparam int B_TMRE = 5;
  localparam int B_PERIPHERAL_IRQ_GATE = 6;
  localparam int B_GIE = 7;
  localparam int B_EDGE = 6;
  localparam logic [7:0] RST_INTERRUPT_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'h40;
  localparam logic [7:0] RST_PCMASK = 8'h00;
  localparam logic [7:0] BANK2_MASK = 8'hf5;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q4 = 2'h3;
  localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
  localparam logic [6:0] SHARED_BYTES = 7'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {SEQ_RUN, SEQ_DUMMY1, SEQ_DUMMY2, SEQ_FETCH} cifl_seq_e;
endpackage
`default_nettype wire

// [include/cifl_evt_if.sv]
// Purpose: Carries pin events and their controls between controller and detector
// Assumes: Both ends on ref_clk_i
// Notes: Edge events are one-cycle pulses; port change holds until a port read reloads the latch
`default_nettype none
interface cifl_evt_if;
  logic polarity;
  logic [7:0] mask;
  logic read_now;
  logic ext_edge;
  logic port_change;
  modport det (input polarity, input mask, input read_now, output ext_edge, output port_change);
  modport ctl (output polarity, output mask, output read_now, input ext_edge, input port_change);
endinterface
`default_nettype wire

// [logic/cifl_event_detect.sv]
// Purpose: Synchronises the pins and detects external edges and port changes
// Assumes: Pins are asynchronous to ref_clk_i
// Notes: Change is measured against the value latched at the last port read
`default_nettype none
module cifl_event_detect (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ext_irq_pin_i,
  input wire logic [7:0] monitored_port_pins_i,
  cifl_evt_if.det evt
);
  logic pin_s1, pin_s2, pin_s3;
  logic [7:0] port_s1, port_s2, port_latch;
  wire rise_seen = pin_s2 & ~pin_s3;
  wire fall_seen = ~pin_s2 & pin_s3;
  wire edge_hit = evt.polarity ? rise_seen : fall_seen;
  wire [7:0] differs = (port_s2 ^ port_latch) & evt.mask;
  // A read in Q2 reloads the latch and hides that cycle's mismatch
  wire change_hit = (|differs) & ~evt.read_now;

  // Two-stage synchronisers; stage one feeds only stage two
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      port_s1 <= 8'h00;
      port_s2 <= 8'h00;
    end else begin
      pin_s1 <= ext_irq_pin_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      port_s1 <= monitored_port_pins_i;
      port_s2 <= port_s1;
    end
  end

  // Latch follows port reads; events leave registered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      port_latch <= 8'h00;
      evt.ext_edge <= 1'b0;
      evt.port_change <= 1'b0;
    end else begin
      if (evt.read_now) begin
        port_latch <= port_s2;
      end
      evt.ext_edge <= edge_hit;
      evt.port_change <= change_hit;
    end
  end
endmodule
`default_nettype wire

// [logic/cifl_top.sv]
// Purpose: Interrupt flags, enables, gating, vectoring and wake for the core
// Assumes: AXI4-Lite master keeps one write and one read outstanding
// Notes: Instruction cycle is four clocks; phase counter free-runs from reset
`default_nettype none
module cifl_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [cifl_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [cifl_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic ext_irq_pin_i,
  input wire logic [7:0] monitored_port_pins_i,
  input wire logic port_read_i,
  input wire logic [7:0] eight_bit_timer_count_i,
  input wire logic [7:0] periph_set_one_i,
  input wire logic [7:0] periph_set_two_i,
  input wire logic sleep_i,
  input wire logic return_from_irq_i,
  input wire logic [cifl_pkg::PC_W-1:0] return_pc_i,
  input wire logic [1:0] bank_sel_i,
  input wire logic [6:0] data_addr_i,
  output logic [1:0] q_phase_o,
  output logic irq_pending_o,
  output logic wake_o,
  output logic dummy_cycle_o,
  output logic vector_fetch_o,
  output logic pc_load_o,
  output logic [cifl_pkg::PC_W-1:0] pc_value_o,
  output logic stack_push_o,
  output logic [cifl_pkg::PC_W-1:0] stack_data_o,
  output logic [8:0] phys_addr_o
);
  import cifl_pkg::*;

  // Index decode shared by the read and write paths
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[ADDR_W-1:2];
    reg_hit = (a[1:0] == 2'h0) && (i == IDX_INTERRUPT_CONTROL_STATUS || i == IDX_PERIPHERAL_FLAGS_ONE || i == IDX_PERIPHERAL_FLAGS_TWO ||
      i == IDX_PERIPHERAL_ENABLES_ONE || i == IDX_PERIPHERAL_ENABLES_TWO || i == IDX_OPTION || i == IDX_PCMASK);
  endfunction

  // Shared low bytes ignore the bank select
  function automatic logic [8:0] map_addr(input logic [1:0] b, input logic [6:0] a);
    map_addr = (a < SHARED_BYTES) ? {2'h0, a} : {b, a};
  endfunction

  logic [7:0] interrupt_control_status, peripheral_flags_one, peripheral_flags_two, peripheral_enables_one, peripheral_enables_two, option_reg, pcmask;
  logic [7:0] next_interrupt_control_status;
  logic [1:0] q_phase;
  logic ext_pend, sleep_q, slp_ext_en, slp_tmr_en, slp_pc_en, slp_per_en;
  logic [7:0] timer_prev;
  cifl_seq_e seq;
  logic aw_full, w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_byte_q;
  logic w_lane_q;

  cifl_evt_if evt ();

  cifl_event_detect cifl_event_detect_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ext_irq_pin_i(ext_irq_pin_i),
    .monitored_port_pins_i(monitored_port_pins_i),
    .evt(evt)
  );

  // Controls toward the detector
  assign evt.polarity = option_reg[B_EDGE];
  assign evt.mask = pcmask;
  assign evt.read_now = port_read_i && (q_phase == Q2);

  // Write path decode; write happens once address and data are both held
  wire wr_fire = aw_full && w_full && !s_axi_bvalid_o;
  wire wr_map = reg_hit(aw_addr_q);
  wire [7:0] wr_idx = aw_addr_q[ADDR_W-1:2];
  wire wr_go = wr_fire && wr_map && w_lane_q;
  wire wr_interrupt_control_status = wr_go && (wr_idx == IDX_INTERRUPT_CONTROL_STATUS);
  wire wr_peripheral_flags_one = wr_go && (wr_idx == IDX_PERIPHERAL_FLAGS_ONE);
  wire wr_peripheral_flags_two = wr_go && (wr_idx == IDX_PERIPHERAL_FLAGS_TWO);
  wire wr_peripheral_enables_one = wr_go && (wr_idx == IDX_PERIPHERAL_ENABLES_ONE);
  wire wr_peripheral_enables_two = wr_go && (wr_idx == IDX_PERIPHERAL_ENABLES_TWO);
  wire wr_opt = wr_go && (wr_idx == IDX_OPTION);
  wire wr_mask = wr_go && (wr_idx == IDX_PCMASK);
  assign s_axi_awready_o = !aw_full && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_full && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  // Read path selection
  wire [7:0] rd_idx = s_axi_araddr_i[ADDR_W-1:2];
  wire rd_map = reg_hit(s_axi_araddr_i);
  wire [7:0] rd_byte = !rd_map ? 8'h00 :
    (rd_idx == IDX_INTERRUPT_CONTROL_STATUS) ? interrupt_control_status :
    (rd_idx == IDX_PERIPHERAL_FLAGS_ONE) ? peripheral_flags_one :
    (rd_idx == IDX_PERIPHERAL_FLAGS_TWO) ? peripheral_flags_two :
    (rd_idx == IDX_PERIPHERAL_ENABLES_ONE) ? peripheral_enables_one :
    (rd_idx == IDX_PERIPHERAL_ENABLES_TWO) ? peripheral_enables_two :
    (rd_idx == IDX_OPTION) ? option_reg : pcmask;

  // Event sources
  wire q4_or_q1 = (q_phase == Q4) || (q_phase == Q1);
  wire ext_set = (ext_pend || evt.ext_edge) && q4_or_q1;
  wire tmr_set = (timer_prev == 8'hff) && (eight_bit_timer_count_i == 8'h00);

  // Request gating
  wire ext_req = interrupt_control_status[B_EXTF] && interrupt_control_status[B_EXTE];
  wire tmr_req = interrupt_control_status[B_TMRF] && interrupt_control_status[B_TMRE];
  wire pc_req = interrupt_control_status[B_PCF] && interrupt_control_status[B_PCE];
  wire per_any = |(peripheral_flags_one & peripheral_enables_one) || |(peripheral_flags_two & peripheral_enables_two);
  wire per_req = per_any && interrupt_control_status[B_PERIPHERAL_IRQ_GATE];
  wire irq_req = ext_req || tmr_req || pc_req || per_req;
  // Taken only at the end of a running cycle, so instruction length never matters
  wire take = interrupt_control_status[B_GIE] && irq_req && (seq == SEQ_RUN) && (q_phase == Q4) && !sleep_i;
  assign irq_pending_o = irq_req;

  // Wake uses the enables captured on the way into sleep, not the global enable
  wire wake_now = sleep_i && sleep_q && ((interrupt_control_status[B_EXTF] && slp_ext_en) ||
    (interrupt_control_status[B_TMRF] && slp_tmr_en) || (interrupt_control_status[B_PCF] && slp_pc_en) ||
    (per_any && slp_per_en));

  // Flag bank: hardware set wins over a software clear in the same cycle
  always_comb begin
    next_interrupt_control_status = wr_interrupt_control_status ? w_byte_q : interrupt_control_status;
    if (ext_set) begin
      next_interrupt_control_status[B_EXTF] = 1'b1;
    end
    if (tmr_set) begin
      next_interrupt_control_status[B_TMRF] = 1'b1;
    end
    if (evt.port_change) begin
      next_interrupt_control_status[B_PCF] = 1'b1;
    end
    if (take) begin
      next_interrupt_control_status[B_GIE] = 1'b0;
    end
    if (return_from_irq_i) begin
      next_interrupt_control_status[B_GIE] = 1'b1;
    end
  end

  // Control and flag registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      interrupt_control_status <= RST_INTERRUPT_CONTROL_STATUS;
      peripheral_flags_one <= RST_PERIPH;
      peripheral_flags_two <= RST_PERIPH;
      peripheral_enables_one <= RST_PERIPH;
      peripheral_enables_two <= RST_PERIPH;
      option_reg <= RST_OPTION;
      pcmask <= RST_PCMASK;
    end else begin
      interrupt_control_status <= next_interrupt_control_status;
      peripheral_flags_one <= (wr_peripheral_flags_one ? w_byte_q : peripheral_flags_one) | periph_set_one_i;
      peripheral_flags_two <= ((wr_peripheral_flags_two ? w_byte_q : peripheral_flags_two) | periph_set_two_i) & BANK2_MASK;
      peripheral_enables_one <= wr_peripheral_enables_one ? w_byte_q : peripheral_enables_one;
      peripheral_enables_two <= wr_peripheral_enables_two ? (w_byte_q & BANK2_MASK) : peripheral_enables_two;
      option_reg <= wr_opt ? (w_byte_q & RST_OPTION) : option_reg;
      pcmask <= wr_mask ? w_byte_q : pcmask;
    end
  end

  // Phase counter, pending edge and sleep capture
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_phase <= Q1;
      ext_pend <= 1'b0;
      timer_prev <= 8'h00;
      sleep_q <= 1'b0;
      slp_ext_en <= 1'b0;
      slp_tmr_en <= 1'b0;
      slp_pc_en <= 1'b0;
      slp_per_en <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      q_phase <= q_phase + 2'h1;
      ext_pend <= (ext_pend || evt.ext_edge) && !q4_or_q1;
      timer_prev <= eight_bit_timer_count_i;
      sleep_q <= sleep_i;
      if (sleep_i && !sleep_q) begin
        slp_ext_en <= interrupt_control_status[B_EXTE];
        slp_tmr_en <= interrupt_control_status[B_TMRE];
        slp_pc_en <= interrupt_control_status[B_PCE];
        slp_per_en <= interrupt_control_status[B_PERIPHERAL_IRQ_GATE];
      end
      wake_o <= wake_now;
    end
  end

  // Vector sequencer advances once per instruction cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      seq <= SEQ_RUN;
      pc_load_o <= 1'b0;
      stack_push_o <= 1'b0;
      stack_data_o <= '0;
    end else begin
      pc_load_o <= 1'b0;
      stack_push_o <= 1'b0;
      if (q_phase == Q4) begin
        case (seq)
          SEQ_RUN: begin
            if (take) begin
              seq <= SEQ_DUMMY1;
              stack_push_o <= 1'b1;
              stack_data_o <= return_pc_i;
            end
          end
          SEQ_DUMMY1: seq <= SEQ_DUMMY2;
          SEQ_DUMMY2: begin
            seq <= SEQ_FETCH;
            pc_load_o <= 1'b1;
          end
          SEQ_FETCH: seq <= SEQ_RUN;
          default: seq <= SEQ_RUN;
        endcase
      end
    end
  end

  // Core-facing status: address from a flip-flop, sequence flags decoded from seq, vector constant
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phys_addr_o <= 9'h000;
    end else begin
      phys_addr_o <= map_addr(bank_sel_i, data_addr_i);
    end
  end
  assign q_phase_o = q_phase;
  assign pc_value_o = VECTOR_ADDR;
  assign dummy_cycle_o = (seq == SEQ_DUMMY1) || (seq == SEQ_DUMMY2);
  assign vector_fetch_o = (seq == SEQ_FETCH);

  // Bus slave: address and data may arrive in either order
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full <= 1'b1;
        w_byte_q <= s_axi_wdata_i[7:0];
        w_lane_q <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h0, rd_byte};
      s_axi_rresp_o <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_ext_flag;
    evt.ext_edge |-> ##[1:4] interrupt_control_status[B_EXTF];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("edge did not set flag");

  property p_ext_take;
    (q_phase == Q4 && seq == SEQ_RUN && interrupt_control_status[B_GIE] && ext_req && !sleep_i)
      |=> seq == SEQ_DUMMY1 && stack_push_o;
  endproperty
  a_ext_take: assert property (p_ext_take) else $error("enabled request not taken");

  property p_no_take;
    (seq == SEQ_RUN && !interrupt_control_status[B_GIE]) |=> !stack_push_o;
  endproperty
  a_no_take: assert property (p_no_take) else $error("vector without global enable");

  property p_tmr_wrap;
    (timer_prev == 8'hff && eight_bit_timer_count_i == 8'h00) |=> interrupt_control_status[B_TMRF];
  endproperty
  a_tmr_wrap: assert property (p_tmr_wrap) else $error("wrap did not set flag");

  property p_port_flag;
    evt.port_change |=> interrupt_control_status[B_PCF];
  endproperty
  a_port_flag: assert property (p_port_flag) else $error("change did not set flag");

  property p_gie_clear;
    (stack_push_o && !$past(return_from_irq_i)) |-> !interrupt_control_status[B_GIE];
  endproperty
  a_gie_clear: assert property (p_gie_clear) else $error("global enable not cleared");

  property p_vector_seq;
    $rose(dummy_cycle_o) |-> dummy_cycle_o[*8] ##1 (vector_fetch_o && pc_load_o);
  endproperty
  a_vector_seq: assert property (p_vector_seq) else $error("bad dummy cycle sequence");

  property p_rfi;
    return_from_irq_i |=> interrupt_control_status[B_GIE];
  endproperty
  a_rfi: assert property (p_rfi) else $error("return did not set global enable");

  property p_wake;
    (sleep_i && sleep_q && slp_ext_en && interrupt_control_status[B_EXTF]) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on enabled pin");

  property p_shared;
    (data_addr_i < SHARED_BYTES) |=> phys_addr_o[8:7] == 2'h0;
  endproperty
  a_shared: assert property (p_shared) else $error("shared byte banked");

  property p_bhold;
    (s_axi_bvalid_o && !s_axi_bready_i) |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
`default_nettype wire

// [verif/cifl_core_model.sv]
// Purpose: Behavioural core fetch and vector side facing the interrupt block
// Assumes: Same clock as the block; requests change only just after a rising edge
// Notes: Counts the vector sequence so the bench can judge its shape
`default_nettype none
module cifl_core_model (
  input wire logic ref_clk_i,
  input wire logic [1:0] q_phase_i,
  input wire logic read_en_i,
  input wire logic ret_req_i,
  input wire logic stack_push_i,
  input wire logic dummy_cycle_i,
  input wire logic vector_fetch_i,
  output logic port_read_o,
  output logic return_from_irq_o,
  output logic [cifl_pkg::PC_W-1:0] return_pc_o,
  output int n_push,
  output int n_dummy,
  output int n_fetch
);
  import cifl_pkg::*;
  // Return address is fixed so a wrong push shows as a plain mismatch
  assign return_pc_o = 13'h0abc;
  // Port read is issued one clock early so it lands in Q2, the risky phase
  always_ff @(posedge ref_clk_i) begin
    port_read_o <= read_en_i && (q_phase_i == Q1);
    return_from_irq_o <= ret_req_i;
    n_push <= n_push + int'(stack_push_i);
    n_dummy <= n_dummy + int'(dummy_cycle_i);
    n_fetch <= n_fetch + int'(vector_fetch_i);
  end
endmodule
`default_nettype wire

// [verif/core_interrupt_flag_logic_tb.sv]
// Purpose: Self-checking bench for the interrupt flag block over AXI4-Lite
// Assumes: 40 MHz clock, synchronous active-high reset held 20 clocks
// Notes: Edges are held 12 clocks so the pin synchroniser settles first
`default_nettype none
module core_interrupt_flag_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cifl_pkg::*;
  localparam logic [9:0] A_CTL = {IDX_INTERRUPT_CONTROL_STATUS, 2'b00};
  localparam logic [9:0] A_F1 = {IDX_PERIPHERAL_FLAGS_ONE, 2'b00};
  localparam logic [9:0] A_F2 = {IDX_PERIPHERAL_FLAGS_TWO, 2'b00};
  localparam logic [9:0] A_E1 = {IDX_PERIPHERAL_ENABLES_ONE, 2'b00};
  localparam logic [9:0] A_E2 = {IDX_PERIPHERAL_ENABLES_TWO, 2'b00};
  localparam logic [9:0] A_OPT = {IDX_OPTION, 2'b00};
  localparam logic [9:0] A_MSK = {IDX_PCMASK, 2'b00};
  logic clk = 0;
  logic rst = 1;
  logic [9:0] awaddr = '0;
  logic [9:0] araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic pin = 0, sleep = 0, rd_en = 0, ret_req = 0;
  logic [7:0] pins = '0, tmr = '0, ps1 = '0;
  logic [1:0] bank = '0;
  logic [6:0] daddr = '0;
  logic awready, wready, bvalid, arready, rvalid, port_read, ret, pend, wake, dum, vf, pcl, push;
  logic [1:0] bresp, rresp, qph;
  logic [31:0] rdata;
  logic [12:0] ret_pc, pcv, sdata;
  logic [8:0] paddr, a0;
  int errors = 0, n_tests = 0, n, p0, d0, f0, n_push, n_dummy, n_fetch;

  cifl_top cifl_top_i (.ref_clk_i(clk), .rst_i(rst), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .ext_irq_pin_i(pin), .monitored_port_pins_i(pins),
    .port_read_i(port_read), .eight_bit_timer_count_i(tmr), .periph_set_one_i(ps1),
    .periph_set_two_i(8'h00), .sleep_i(sleep), .return_from_irq_i(ret),
    .return_pc_i(ret_pc), .bank_sel_i(bank), .data_addr_i(daddr), .q_phase_o(qph),
    .irq_pending_o(pend), .wake_o(wake), .dummy_cycle_o(dum), .vector_fetch_o(vf),
    .pc_load_o(pcl), .pc_value_o(pcv), .stack_push_o(push), .stack_data_o(sdata),
    .phys_addr_o(paddr));

  cifl_core_model cifl_core_model_i (.ref_clk_i(clk), .q_phase_i(qph), .read_en_i(rd_en),
    .ret_req_i(ret_req), .stack_push_i(push), .dummy_cycle_i(dum), .vector_fetch_i(vf),
    .port_read_o(port_read), .return_from_irq_o(ret), .return_pc_o(ret_pc),
    .n_push(n_push), .n_dummy(n_dummy), .n_fetch(n_fetch));

  // Free-running 25 ns clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1;
    pw = 1;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge clk); while (!bvalid);
    check(bresp, er);
    @(posedge clk);
    bready <= 0;
  endtask

  // Read: ready is judged before the edge so the handshake edge is known
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 0;
    do @(negedge clk); while (!rvalid);
    check(rdata, {24'h0, e});
    check(rresp, er);
    @(posedge clk);
    rready <= 0;
  endtask

  task automatic edge_to(input logic v);
    @(posedge clk);
    pin <= v;
    cyc(12);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the whole sequence
  initial begin
    cyc(20000);
    errors++;
    complete_run;
  end

  initial begin
    cyc(20);
    rst <= 0;
    rd_en <= 1;
    // Reset values, masks and unmapped access
    rd(A_CTL, 8'h00, RESP_OKAY);
    rd(A_F1, 8'h00, RESP_OKAY);
    rd(A_F2, 8'h00, RESP_OKAY);
    rd(A_E1, 8'h00, RESP_OKAY);
    wr(A_E2, 8'hff, RESP_OKAY);
    rd(A_E2, BANK2_MASK, RESP_OKAY);
    wr(A_E2, 8'h00, RESP_OKAY);
    rd(10'h3fc, 8'h00, RESP_SLVERR);
    wr(10'h3fc, 8'hff, RESP_SLVERR);
    $display("test registers done");
    // External edge, both polarities, enables off
    edge_to(1);
    rd(A_CTL, 8'h02, RESP_OKAY);
    check(pend, 0);
    wr(A_CTL, 8'h00, RESP_OKAY);
    wr(A_OPT, 8'h00, RESP_OKAY);
    edge_to(0);
    rd(A_CTL, 8'h02, RESP_OKAY);
    wr(A_CTL, 8'h00, RESP_OKAY);
    edge_to(1);
    rd(A_CTL, 8'h00, RESP_OKAY);
    wr(A_OPT, 8'h40, RESP_OKAY);
    $display("test external edge done");
    // Timer wrap and its gate
    @(posedge clk);
    tmr <= 8'hff;
    @(posedge clk);
    tmr <= 8'h00;
    cyc(2);
    rd(A_CTL, 8'h04, RESP_OKAY);
    check(pend, 0);
    wr(A_CTL, 8'h24, RESP_OKAY);
    check(pend, 1);
    wr(A_CTL, 8'h00, RESP_OKAY);
    $display("test timer done");
    // Port change with per-pin mask
    wr(A_MSK, 8'h01, RESP_OKAY);
    // Port reads paused so a change can never land in the read cycle
    @(posedge clk);
    rd_en <= 0;
    @(posedge clk);
    pins <= 8'h02;
    cyc(12);
    rd(A_CTL, 8'h00, RESP_OKAY);
    @(posedge clk);
    pins <= 8'h03;
    cyc(12);
    rd(A_CTL, 8'h01, RESP_OKAY);
    @(posedge clk);
    rd_en <= 1;
    cyc(8);
    wr(A_CTL, 8'h09, RESP_OKAY);
    check(pend, 1);
    wr(A_CTL, 8'h00, RESP_OKAY);
    $display("test port change done");
    // Peripheral flag, enable and gate
    @(posedge clk);
    ps1 <= 8'h10;
    @(posedge clk);
    ps1 <= 8'h00;
    rd(A_F1, 8'h10, RESP_OKAY);
    wr(A_E1, 8'h10, RESP_OKAY);
    check(pend, 0);
    wr(A_CTL, 8'h40, RESP_OKAY);
    check(pend, 1);
    wr(A_F1, 8'h00, RESP_OKAY);
    wr(A_E1, 8'h00, RESP_OKAY);
    $display("test peripheral done");
    // Vectoring on an external edge
    edge_to(0);
    wr(A_CTL, 8'h90, RESP_OKAY);
    p0 = n_push;
    d0 = n_dummy;
    f0 = n_fetch;
    @(posedge clk);
    pin <= 1;
    // Pending rises with the flag; the synchroniser delay is the pin's own
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!pend && n < 40);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!pcl && n < 40);
    // Flag cycle plus these clocks must span three to four instruction cycles
    check(n >= 11 && n <= 15, 1);
    check(pcv, VECTOR_ADDR);
    cyc(6);
    check(n_push - p0, 1);
    check(sdata, 13'h0abc);
    check(n_dummy - d0, 8);
    check(n_fetch - f0, 4);
    rd(A_CTL, 8'h12, RESP_OKAY);
    wr(A_CTL, 8'h10, RESP_OKAY);
    @(posedge clk);
    ret_req <= 1;
    @(posedge clk);
    ret_req <= 0;
    cyc(3);
    rd(A_CTL, 8'h90, RESP_OKAY);
    wr(A_CTL, 8'h00, RESP_OKAY);
    $display("test vector done");
    // Wake from sleep needs the enable set beforehand, not the global enable
    edge_to(0);
    @(posedge clk);
    sleep <= 1;
    edge_to(1);
    check(wake, 0);
    @(posedge clk);
    sleep <= 0;
    wr(A_CTL, 8'h10, RESP_OKAY);
    edge_to(0);
    p0 = n_push;
    @(posedge clk);
    sleep <= 1;
    edge_to(1);
    check(wake, 1);
    @(posedge clk);
    sleep <= 0;
    cyc(12);
    check(n_push - p0, 0);
    wr(A_CTL, 8'h00, RESP_OKAY);
    $display("test sleep done");
    // Shared low bytes reach one place from banks 0 and 3
    @(posedge clk);
    daddr <= 7'h05;
    cyc(3);
    a0 = paddr;
    @(posedge clk);
    bank <= 2'h3;
    cyc(3);
    check(paddr, a0);
    @(posedge clk);
    daddr <= 7'h20;
    cyc(3);
    a0 = paddr;
    @(posedge clk);
    bank <= 2'h0;
    cyc(3);
    check(paddr !== a0, 1);
    $display("test banking done");
    complete_run;
  end
endmodule
`default_nettype wire
